// file: core/ssrx_core.sv
// secondary serial port receive slot map for channels 7 and 8 with fifo and axi4-lite
// How it works
// (R1) channel 7 route field bits 6-5: off, playback 7, adc 3 loopback, linked device 2
// (R2) channel 8 route field: off, playback 8, adc 4 loopback, linked device 3
// (R3) channel 7 slot field bits 4-0 picks its slot, resets to six
// (R4) channel 8 slot field picks its slot, resets to seven
// (R5) tdm code is slot 0-31; i2s and left-justified: 0-15 left, 16-31 right
// (R6) bit 7 written only as zero by software; reads back zero
// (R7) channel 8 register at 0x2F, resets to 0x07: disabled, slot seven
// (R8) enabled channel captures its slot once per frame and delivers it
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// fifo
module ssrx_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [CW-1:0] count, next_count;
	logic          push, pop;

	always_comb begin
		in_ready_o  = (count != CW'(DEPTH));
		out_valid_o = (count != '0);
		out_data_o  = mem[rd_ptr];
		push        = in_valid_i & in_ready_o;
		pop         = out_valid_o & out_ready_i;
		next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
		next_count  = count + CW'(push) - CW'(pop);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
endmodule

// ============================================================
// top
module ssrx_core
	import ssrx_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic              CLOCK_I,
	input  wire logic              RESETN_I,
	input  wire logic [ADDR_W-1:0] AWADDR_I,
	input  wire logic              AWVALID_I,
	output logic                   AWREADY_O,
	input  wire logic [DATA_W-1:0] WDATA_I,
	input  wire logic [3:0]        WSTRB_I,
	input  wire logic              WVALID_I,
	output logic                   WREADY_O,
	output logic [1:0]             BRESP_O,
	output logic                   BVALID_O,
	input  wire logic              BREADY_I,
	input  wire logic [ADDR_W-1:0] ARADDR_I,
	input  wire logic              ARVALID_I,
	output logic                   ARREADY_O,
	output logic [DATA_W-1:0]      RDATA_O,
	output logic [1:0]             RRESP_O,
	output logic                   RVALID_O,
	input  wire logic              RREADY_I,
	input  wire logic              BIT_CLOCK_I,
	input  wire logic              FRAME_SYNC_I,
	input  wire logic              SERIAL_DATA_I,
	output logic                   SAMPLE_VALID_O,
	output logic [DATA_W-1:0]      SAMPLE_DATA_O,
	output logic                   SAMPLE_CHANNEL_O,
	output logic [1:0]             SAMPLE_ROUTE_O,
	input  wire logic              SAMPLE_READY_I
);
	// ============================================================
	// reset release and pin synchronisers
	logic [1:0] rst_sync;
	logic       rst_n;
	logic [2:0] pin_meta, pin_sync;

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rst_sync <= '0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {BIT_CLOCK_I, FRAME_SYNC_I, SERIAL_DATA_I};
			pin_sync <= pin_meta;
		end
	end

	// ============================================================
	// register state
	logic [7:0]        rx7_cfg, rx8_cfg, ctrl, next_rx7_cfg, next_rx8_cfg, next_ctrl;
	logic [ADDR_W-1:0] aw_addr, next_aw_addr;
	logic [7:0]        w_data, next_w_data;
	logic              aw_have, w_have, w_lane, next_aw_have, next_w_have, next_w_lane;
	logic              next_bvalid, next_rvalid;
	logic [1:0]        next_bresp, next_rresp;
	logic [DATA_W-1:0] next_rdata;
	logic              ovf, next_ovf, ovf_evt, ovf_clr, do_wr;
	logic              locked;
	logic [4:0]        last_code;
	ssrx_fmt_e         fmt;
	logic [5:0]        wl;
	logic              en;

	always_comb begin
		fmt = ssrx_fmt_e'(ctrl[FMT_LO +: 2]);
		en  = ctrl[EN_BIT];
		case (ctrl[WL_LO +: 2])
			2'h0:    wl = WL_16;
			2'h1:    wl = WL_20;
			2'h2:    wl = WL_24;
			default: wl = WL_32;
		endcase
	end

	always_comb begin
		next_aw_addr = (AWVALID_I & AWREADY_O) ? AWADDR_I : aw_addr;
		next_w_data  = (WVALID_I & WREADY_O) ? WDATA_I[7:0] : w_data;
		next_w_lane  = (WVALID_I & WREADY_O) ? WSTRB_I[0] : w_lane;
		next_aw_have = aw_have | (AWVALID_I & AWREADY_O);
		next_w_have  = w_have | (WVALID_I & WREADY_O);
		do_wr        = aw_have & w_have & ~BVALID_O;
		next_rx7_cfg = rx7_cfg;
		next_rx8_cfg = rx8_cfg;
		next_ctrl    = ctrl;
		next_bresp   = BRESP_O;
		next_bvalid  = BVALID_O & ~BREADY_I;
		ovf_clr      = 1'b0;
		if (do_wr) begin
			next_aw_have = 1'b0;
			next_w_have  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RESP_OKAY;
			if (aw_addr == RX7_ADDR) begin
				if (w_lane) next_rx7_cfg = {1'b0, w_data[ROUTE_HI:SLOT_LO]}; // (R1) (R3) (R6)
			end else if (aw_addr == RX8_ADDR) begin
				if (w_lane) next_rx8_cfg = {1'b0, w_data[ROUTE_HI:SLOT_LO]}; // (R2) (R4) (R6) (R7)
			end else if (aw_addr == CTRL_ADDR) begin
				if (w_lane) next_ctrl = {3'b000, w_data[EN_BIT:0]};
			end else if (aw_addr == STATUS_ADDR) begin
				ovf_clr = w_lane & w_data[ST_OVF_BIT];
			end else begin
				next_bresp = RESP_SLVERR;
			end
		end
		next_ovf = (ovf & ~ovf_clr) | ovf_evt;
		next_rdata  = RDATA_O;
		next_rresp  = RRESP_O;
		next_rvalid = RVALID_O & ~RREADY_I;
		if (ARVALID_I & ARREADY_O) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			next_rdata  = '0;
			if (ARADDR_I == RX7_ADDR) begin
				next_rdata[7:0] = rx7_cfg; // (R6)
			end else if (ARADDR_I == RX8_ADDR) begin
				next_rdata[7:0] = rx8_cfg; // (R6)
			end else if (ARADDR_I == CTRL_ADDR) begin
				next_rdata[7:0] = ctrl;
			end else if (ARADDR_I == STATUS_ADDR) begin
				next_rdata[ST_OVF_BIT]        = ovf;
				next_rdata[ST_LOCK_BIT]       = locked;
				next_rdata[ST_AVAIL_BIT]      = SAMPLE_VALID_O;
				next_rdata[ST_CODE_LO +: 5]   = last_code;
			end else begin
				next_rresp = RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			rx7_cfg   <= RX7_RESET; // (R3)
			rx8_cfg   <= RX8_RESET; // (R4) (R7)
			ctrl      <= CTRL_RESET;
			aw_addr   <= '0;
			w_data    <= '0;
			w_lane    <= 1'b0;
			aw_have   <= 1'b0;
			w_have    <= 1'b0;
			AWREADY_O <= 1'b0;
			WREADY_O  <= 1'b0;
			BVALID_O  <= 1'b0;
			BRESP_O   <= RESP_OKAY;
			ARREADY_O <= 1'b0;
			RVALID_O  <= 1'b0;
			RRESP_O   <= RESP_OKAY;
			RDATA_O   <= '0;
			ovf       <= 1'b0;
		end else begin
			rx7_cfg   <= next_rx7_cfg;
			rx8_cfg   <= next_rx8_cfg;
			ctrl      <= next_ctrl;
			aw_addr   <= next_aw_addr;
			w_data    <= next_w_data;
			w_lane    <= next_w_lane;
			aw_have   <= next_aw_have;
			w_have    <= next_w_have;
			AWREADY_O <= ~next_aw_have;
			WREADY_O  <= ~next_w_have;
			BVALID_O  <= next_bvalid;
			BRESP_O   <= next_bresp;
			ARREADY_O <= ~next_rvalid;
			RVALID_O  <= next_rvalid;
			RRESP_O   <= next_rresp;
			RDATA_O   <= next_rdata;
			ovf       <= next_ovf;
		end
	end

	// ============================================================
	// frame and slot tracking
	logic              bclk_q, ws_d, ws_dd, half, next_bclk_q, next_ws_d, next_ws_dd, next_half;
	logic              next_locked, rise, start, eff_now, eff_prev, cur_half, last_bit, code_ok;
	logic [5:0]        bit_cnt, slot, next_bit_cnt, next_slot, cur_bit, cur_slot;
	logic [DATA_W-1:0] sr, next_sr, word;
	logic [4:0]        code, next_last_code;
	logic              hit7, hit8;

	always_comb begin
		rise     = pin_sync[2] & ~bclk_q;
		eff_now  = (fmt == FMT_I2S) ? ws_d : pin_sync[1];
		eff_prev = (fmt == FMT_I2S) ? ws_dd : ws_d;
		start    = (fmt == FMT_I2S || fmt == FMT_LEFT_JUST) ? (eff_now != eff_prev)
			: (pin_sync[1] & ~ws_d);
		cur_half = (fmt == FMT_I2S) ? eff_now : ((fmt == FMT_LEFT_JUST) ? ~eff_now : 1'b0);
		cur_bit  = start ? '0 : bit_cnt;
		cur_slot = start ? '0 : slot;
		last_bit = (cur_bit == wl - 6'h01);
		next_sr  = {sr[DATA_W-2:0], pin_sync[0]};
		word     = next_sr << (WL_32 - wl);
		code     = start ? (cur_half ? HALF_RIGHT_CODE : '0)
			: (half ? (HALF_RIGHT_CODE | slot[4:0]) : slot[4:0]); // (R5)
		code_ok  = (fmt == FMT_I2S || fmt == FMT_LEFT_JUST) ? (cur_slot < HALF_SLOTS)
			: (cur_slot < TDM_SLOTS); // (R5)
		next_bclk_q    = pin_sync[2];
		next_ws_d      = ws_d;
		next_ws_dd     = ws_dd;
		next_half      = half;
		next_bit_cnt   = bit_cnt;
		next_slot      = slot;
		next_locked    = locked & en;
		next_last_code = last_code;
		hit7           = 1'b0;
		hit8           = 1'b0;
		if (rise & en) begin
			next_ws_d  = pin_sync[1];
			next_ws_dd = ws_d;
			if (start) begin
				next_locked = 1'b1;
				next_half   = cur_half;
			end
			if (start | locked) begin
				next_bit_cnt = last_bit ? '0 : cur_bit + 6'h01;
				next_slot    = (last_bit && cur_slot != '1) ? cur_slot + 6'h01 : cur_slot;
				if (last_bit & code_ok) begin
					next_last_code = code;
					hit7 = (rx7_cfg[ROUTE_HI:ROUTE_LO] != ROUTE_OFF)
						&& (code == rx7_cfg[SLOT_HI:SLOT_LO]); // (R1) (R3) (R8)
					hit8 = (rx8_cfg[ROUTE_HI:ROUTE_LO] != ROUTE_OFF)
						&& (code == rx8_cfg[SLOT_HI:SLOT_LO]); // (R2) (R4) (R8)
				end
			end
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			bclk_q    <= 1'b0;
			ws_d      <= 1'b0;
			ws_dd     <= 1'b0;
			half      <= 1'b0;
			bit_cnt   <= '0;
			slot      <= '0;
			locked    <= 1'b0;
			last_code <= '0;
			sr        <= '0;
		end else begin
			bclk_q    <= next_bclk_q;
			ws_d      <= next_ws_d;
			ws_dd     <= next_ws_dd;
			half      <= next_half;
			bit_cnt   <= next_bit_cnt;
			slot      <= next_slot;
			locked    <= next_locked;
			last_code <= next_last_code;
			sr        <= (rise & en) ? next_sr : sr;
		end
	end

	// ============================================================
	// delivery through the fifo
	logic                pend7, pend8, next_pend7, next_pend8, push7, push8;
	logic [DATA_W-1:0]   word7, word8, next_word7, next_word8;
	logic                f_in_ready, f_out_valid, f_out_ready, next_s_valid;
	logic [SAMPLE_W-1:0] f_in_data, f_out_data, next_s_pack;

	always_comb begin
		push7      = pend7 & f_in_ready;
		push8      = pend8 & ~pend7 & f_in_ready;
		f_in_data  = pend7 ? {1'b0, rx7_cfg[ROUTE_HI:ROUTE_LO], word7}
			: {1'b1, rx8_cfg[ROUTE_HI:ROUTE_LO], word8}; // (R1) (R2) (R8)
		next_pend7 = (pend7 & ~push7) | hit7;
		next_pend8 = (pend8 & ~push8) | hit8;
		next_word7 = hit7 ? word : word7;
		next_word8 = hit8 ? word : word8;
		ovf_evt    = (hit7 & pend7 & ~push7) | (hit8 & pend8 & ~push8);
		f_out_ready  = ~SAMPLE_VALID_O | SAMPLE_READY_I;
		next_s_valid = f_out_ready ? f_out_valid : SAMPLE_VALID_O;
		next_s_pack  = (f_out_ready & f_out_valid) ? f_out_data
			: {SAMPLE_CHANNEL_O, SAMPLE_ROUTE_O, SAMPLE_DATA_O};
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			pend7            <= 1'b0;
			pend8            <= 1'b0;
			word7            <= '0;
			word8            <= '0;
			SAMPLE_VALID_O   <= 1'b0;
			SAMPLE_CHANNEL_O <= 1'b0;
			SAMPLE_ROUTE_O   <= '0;
			SAMPLE_DATA_O    <= '0;
		end else begin
			pend7            <= next_pend7;
			pend8            <= next_pend8;
			word7            <= next_word7;
			word8            <= next_word8;
			SAMPLE_VALID_O   <= next_s_valid;
			SAMPLE_CHANNEL_O <= next_s_pack[SAMPLE_W-1];
			SAMPLE_ROUTE_O   <= next_s_pack[DATA_W +: 2];
			SAMPLE_DATA_O    <= next_s_pack[DATA_W-1:0];
		end
	end

	ssrx_fifo #(
		.W     (SAMPLE_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_i       (CLOCK_I),
		.rst_n_i     (rst_n),
		.in_valid_i  (pend7 | pend8),
		.in_ready_o  (f_in_ready),
		.in_data_i   (f_in_data),
		.out_valid_o (f_out_valid),
		.out_ready_i (f_out_ready),
		.out_data_o  (f_out_data)
	);
endmodule

`default_nettype wire

// file: core/ssrx_pkg.sv
// constants and types for the secondary serial port receive slot map
package ssrx_pkg;
	// ============================================================
	// register map
	localparam int          ADDR_W          = 10;
	localparam int          DATA_W          = 32;
	localparam logic [7:0]  RX7_INDEX       = 8'h2E;
	localparam logic [7:0]  RX8_INDEX       = 8'h2F;
	localparam logic [9:0]  RX7_ADDR        = {RX7_INDEX, 2'b00};
	localparam logic [9:0]  RX8_ADDR        = {RX8_INDEX, 2'b00};
	localparam logic [9:0]  CTRL_ADDR       = 10'h0C0;
	localparam logic [9:0]  STATUS_ADDR     = 10'h0C4;
	localparam logic [7:0]  RX7_RESET       = 8'h06;
	localparam logic [7:0]  RX8_RESET       = 8'h07;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	// ============================================================
	// channel register fields
	localparam int          RSVD_BIT        = 7;
	localparam int          ROUTE_HI        = 6;
	localparam int          ROUTE_LO        = 5;
	localparam int          SLOT_HI         = 4;
	localparam int          SLOT_LO         = 0;
	localparam logic [4:0]  HALF_RIGHT_CODE = 5'h10;
	localparam logic [5:0]  TDM_SLOTS       = 6'h20;
	localparam logic [5:0]  HALF_SLOTS      = 6'h10;
	// ============================================================
	// own control and status fields
	localparam int          FMT_LO          = 0;
	localparam int          WL_LO           = 2;
	localparam int          EN_BIT          = 4;
	localparam int          ST_OVF_BIT      = 0;
	localparam int          ST_LOCK_BIT     = 1;
	localparam int          ST_AVAIL_BIT    = 2;
	localparam int          ST_CODE_LO      = 8;
	// ============================================================
	// axi responses
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	// ============================================================
	// types, word lengths and sizes
	typedef enum logic [1:0] {ROUTE_OFF, ROUTE_PLAYBACK, ROUTE_ADC_LOOP, ROUTE_LINKED} ssrx_route_e;
	typedef enum logic [1:0] {FMT_TDM, FMT_I2S, FMT_LEFT_JUST, FMT_SPARE} ssrx_fmt_e;
	localparam logic [5:0]  WL_16           = 6'h10;
	localparam logic [5:0]  WL_20           = 6'h14;
	localparam logic [5:0]  WL_24           = 6'h18;
	localparam logic [5:0]  WL_32           = 6'h20;
	localparam int          FIFO_DEPTH      = 4;
	localparam int          SAMPLE_W        = DATA_W + 3;
endpackage

// file: tb/ssrx_core_checker.sv
// concurrent checks on the slot map top ports
`timescale 1ns/100ps
`default_nettype none
module ssrx_core_checker
	import ssrx_pkg::*;
(
	input wire logic              CLOCK_I,
	input wire logic              RESETN_I,
	input wire logic              AWVALID_I,
	input wire logic              AWREADY_O,
	input wire logic              WVALID_I,
	input wire logic              WREADY_O,
	input wire logic              BVALID_O,
	input wire logic              BREADY_I,
	input wire logic              ARVALID_I,
	input wire logic              ARREADY_O,
	input wire logic              RVALID_O,
	input wire logic              RREADY_I,
	input wire logic              SAMPLE_VALID_O,
	input wire logic              SAMPLE_READY_I,
	input wire logic [DATA_W-1:0] SAMPLE_DATA_O,
	input wire logic              SAMPLE_CHANNEL_O,
	input wire logic [1:0]        SAMPLE_ROUTE_O
);
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RESETN_I);
	// ============================================================
	// register bus
	write_answer_a: assert property (
		AWVALID_I && AWREADY_O && WVALID_I && WREADY_O && !BVALID_O |-> ##2 BVALID_O)
		else $error("write answer not two cycles after handshake");
	write_busy_a: assert property (AWVALID_I && AWREADY_O |=> !AWREADY_O)
		else $error("write address ready not dropped");
	b_release_a: assert property (BVALID_O && BREADY_I |=> !BVALID_O)
		else $error("write answer not released");
	read_answer_a: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
		else $error("read answer late");
	read_busy_a: assert property (ARVALID_I && ARREADY_O |=> !ARREADY_O ##1 (ARREADY_O != RVALID_O))
		else $error("read address ready back too soon");
	r_release_a: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
		else $error("read answer not released");
	// ============================================================
	// sample output
	sample_route_a: assert property (SAMPLE_VALID_O |-> SAMPLE_ROUTE_O != 2'h0)
		else $error("sample offered for disabled route");
	sample_hold_a: assert property (SAMPLE_VALID_O && !SAMPLE_READY_I |=> SAMPLE_VALID_O
		&& $stable(SAMPLE_DATA_O) && $stable(SAMPLE_CHANNEL_O) && $stable(SAMPLE_ROUTE_O))
		else $error("stalled sample changed");
endmodule
bind ssrx_core ssrx_core_checker u_ssrx_core_checker (.*);
`default_nettype wire

// file: tb/ssrx_serial_model.sv
// far side model driving serial frames
`timescale 1ns/100ps
`default_nettype none
module ssrx_serial_model
	import ssrx_pkg::*;
(
	input  wire logic clk_i,
	output logic      bclk_o,
	output logic      fs_o,
	output logic      sd_o
);
	initial begin
		bclk_o = 1'b0;
		fs_o   = 1'b0;
		sd_o   = 1'b0;
	end
	// one bit, changed while the bit clock is low
	task automatic put(input logic s, input logic d);
		fs_o   <= s;
		sd_o   <= d;
		repeat (4) @(posedge clk_i);
		bclk_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		bclk_o <= 1'b0;
	endtask
	// 512 bits of nb-bit slots msb first; halves of 256 bits outside tdm; clock still after
	task automatic frame(input ssrx_fmt_e f, input int nb, input logic [31:0] w[32]);
		logic lvl;
		int   s, q, x;
		lvl = (f == FMT_LEFT_JUST);
		for (int b = (f == FMT_I2S) ? -2 : -1; b < 512; b++) begin
			s = (f == FMT_I2S) ? b + 1 : b;
			q = (f == FMT_TDM) ? b : b % 256;
			x = (f == FMT_TDM) ? q / nb : (b / 256) * 16 + q / nb;
			put((f == FMT_TDM) ? (s == 0) : ((s >= 0 && s < 256) ? lvl : !lvl),
				(b >= 0) ? w[x][nb - 1 - q % nb] : !sd_o);
		end
		sd_o <= !sd_o;
	endtask
endmodule
`default_nettype wire

// file: tb/test_ssrx_core.sv
// self-checking bench for the secondary serial receive slot map
`timescale 1ns/100ps
`default_nettype none
module test_ssrx_core
	import ssrx_pkg::*;
	;
	logic              CLOCK_I = 1'b0;
	logic              RESETN_I = 1'b0;
	logic [ADDR_W-1:0] AWADDR_I = '0, ARADDR_I = '0;
	logic [DATA_W-1:0] WDATA_I = '0;
	logic [3:0]        WSTRB_I = 4'h0;
	logic              AWVALID_I = 1'b0, WVALID_I = 1'b0, BREADY_I = 1'b0;
	logic              ARVALID_I = 1'b0, RREADY_I = 1'b0, SAMPLE_READY_I = 1'b0;
	logic              AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
	logic [1:0]        BRESP_O, RRESP_O, SAMPLE_ROUTE_O;
	logic [DATA_W-1:0] RDATA_O, SAMPLE_DATA_O;
	logic              SAMPLE_VALID_O, SAMPLE_CHANNEL_O;
	logic              BIT_CLOCK_I, FRAME_SYNC_I, SERIAL_DATA_I;
	int                n_fail = 0, n_checks = 0;
	logic [34:0]       got[$];
	logic [31:0]       w[32];
	always #4 CLOCK_I = ~CLOCK_I;
	ssrx_core u_ssrx_core (.*);
	ssrx_serial_model u_ssrx_serial_model (
		.clk_i  (CLOCK_I),
		.bclk_o (BIT_CLOCK_I),
		.fs_o   (FRAME_SYNC_I),
		.sd_o   (SERIAL_DATA_I)
	);
	// ============================================================
	// sink with random stalls
	always @(posedge CLOCK_I) begin
		SAMPLE_READY_I <= 1'($urandom_range(0, 1));
		if (SAMPLE_VALID_O === 1'b1 && SAMPLE_READY_I === 1'b1)
			got.push_back({SAMPLE_CHANNEL_O, SAMPLE_ROUTE_O, SAMPLE_DATA_O});
	end
	// ============================================================
	// helpers
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic axw(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
		AWADDR_I  <= a;
		WDATA_I   <= {24'h00_0000, d};
		WSTRB_I   <= 4'hf;
		AWVALID_I <= 1'b1;
		WVALID_I  <= 1'b1;
		BREADY_I  <= 1'b1;
		do begin
			@(posedge CLOCK_I);
			if (AWREADY_O === 1'b1) AWVALID_I <= 1'b0;
			if (WREADY_O === 1'b1) WVALID_I <= 1'b0;
		end while (BVALID_O !== 1'b1);
		BREADY_I <= 1'b0;
		check("bresp", BRESP_O, er);
		@(posedge CLOCK_I);
	endtask
	task automatic axr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
		ARADDR_I  <= a;
		ARVALID_I <= 1'b1;
		RREADY_I  <= 1'b1;
		do begin
			@(posedge CLOCK_I);
			if (ARREADY_O === 1'b1) ARVALID_I <= 1'b0;
		end while (RVALID_O !== 1'b1);
		RREADY_I <= 1'b0;
		check("rdata", RDATA_O, {24'h00_0000, d});
		check("rresp", RRESP_O, er);
		@(posedge CLOCK_I);
	endtask
	// frame position of a slot code: left half 0-15, right half 16-31
	function automatic int slot_pos(input ssrx_fmt_e f, input logic [4:0] c);
		return (f == FMT_TDM) ? int'(c) : (c[4] ? 16 : 0) + int'(c[3:0]);
	endfunction
	// a slot counts only when all its bits lie inside the frame or half-frame
	function automatic bit fits(input ssrx_fmt_e f, input logic [4:0] c, input int nb);
		return (f == FMT_TDM) ? (int'(c) + 1) * nb <= 512 : (int'(c[3:0]) + 1) * nb <= 256;
	endfunction
	// sample left-aligned, low bits zero for short words
	function automatic logic [34:0] sample(input logic ch, input logic [1:0] rt,
		input logic [31:0] d, input int nb);
		return {ch, rt, 32'(d << (32 - nb))};
	endfunction
	// ============================================================
	// main sequence
	initial begin
		ssrx_fmt_e   fl[3];
		logic [1:0]  r7;
		logic [4:0]  c7, c8;
		int          p7, p8, k, nb;
		logic [34:0] ex[$];
		k = $urandom(32'h50ad);
		fl = '{FMT_TDM, FMT_LEFT_JUST, FMT_I2S};
		repeat (3) @(posedge CLOCK_I);
		RESETN_I <= 1'b1;
		repeat (6) @(posedge CLOCK_I);
		axr(RX7_ADDR, 8'h06, RESP_OKAY);
		axr(RX8_ADDR, 8'h07, RESP_OKAY);
		axw(RX8_ADDR, 8'hff, RESP_OKAY);
		axr(RX8_ADDR, 8'h7f, RESP_OKAY);
		axw(10'h3fc, 8'h01, RESP_SLVERR);
		axr(10'h3fc, 8'h00, RESP_SLVERR);
		foreach (fl[i]) for (int r = 0; r < 4; r++) begin
			c7 = (r == 0) ? 5'h1f : (r == 1) ? 5'h00 : 5'($urandom_range(0, 31));
			c8 = (r == 3) ? c7 : 5'($urandom_range(0, 31));
			r7 = 2'(1 + r % 3);
			nb = (r == 3) ? 32 : 16 + 4 * r;
			axw(CTRL_ADDR, {3'h0, 1'b1, 2'(r), 2'(fl[i])}, RESP_OKAY);
			axw(RX7_ADDR, {1'b0, r7, c7}, RESP_OKAY);
			axw(RX8_ADDR, {1'b0, 2'(r), c8}, RESP_OKAY);
			foreach (w[j]) w[j] = $urandom();
			got.delete();
			u_ssrx_serial_model.frame(fl[i], nb, w);
			repeat (300) @(posedge CLOCK_I);
			p7 = slot_pos(fl[i], c7);
			p8 = slot_pos(fl[i], c8);
			ex.delete();
			if (fits(fl[i], c7, nb)) ex.push_back(sample(1'b0, r7, w[p7], nb));
			if (r != 0 && fits(fl[i], c8, nb)) begin
				if (p8 < p7) ex.push_front(sample(1'b1, 2'(r), w[p8], nb));
				else ex.push_back(sample(1'b1, 2'(r), w[p8], nb));
			end
			check("count", got.size(), ex.size());
			foreach (ex[j]) check("sample", got[j], ex[j]);
		end
		final_report();
	end
	initial begin
		#(95000 * 8);
		n_fail++;
		final_report();
	end
endmodule
`default_nettype wire
